// ==== design/dlsc_top.sv ====
// serial configuration port of a triple video delay line
// Notes on behaviour
// - first bit sampled on first falling edge
// - next two bits select target register
// - last five bits are the payload
// - after eight bits a new word starts
// - bits shift straight into final registers
// - all registers zero after power-up
// - test bit zero selects test mode
// - test bits one to four set slicer
// - slicer code is signed, 50 mV steps
// - test mode reroutes green and probes
// - data captured on falling shift edge
module dlsc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic shift_clock,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  output logic [4:0] red_delay_code,
  output logic [4:0] green_delay_code,
  output logic [4:0] blue_delay_code,
  output logic [5:0] red_delay_ns,
  output logic [5:0] green_delay_ns,
  output logic [5:0] blue_delay_ns,
  output logic test_mode,
  output logic [3:0] slice_code,
  output logic signed [9:0] slice_mv,
  output logic green_shows_slicer,
  output logic red_blue_probe_self,
  output logic config_update
);

  function automatic dlsc_pkg::dlsc_phase_t phase_of(input logic [2:0] pos);
    if (pos == dlsc_pkg::WRITE_BIT_POS)
      return dlsc_pkg::PH_WRITE;
    else if (pos < dlsc_pkg::FIRST_PAYLOAD_POS)
      return dlsc_pkg::PH_SELECT;
    else
      return dlsc_pkg::PH_PAYLOAD;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [dlsc_pkg::RST_STAGES-1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_pipe <= '0;
    else
      rst_pipe <= {rst_pipe[dlsc_pkg::RST_STAGES-2:0], 1'h1};
  end

  assign rst_n = rst_pipe[dlsc_pkg::RST_STAGES-1];

  //////////////////////////////////////////////////////////////////////////////
  // link domain, clocked on the falling shift edge
  logic [2:0] bit_pos;
  logic write_ok;
  logic [1:0] reg_sel;
  logic [4:0] cfg [dlsc_pkg::NUM_REGS];
  logic word_toggle;
  logic link_phase_payload;
  logic [4:0] cur_reg;

  assign link_phase_payload = (phase_of(bit_pos) == dlsc_pkg::PH_PAYLOAD);
  assign cur_reg = cfg[reg_sel];

  // bit position within the word, cleared while select is high
  always_ff @(negedge shift_clock or negedge rst_n or posedge serial_select_n)
  begin
    if (!rst_n)
      bit_pos <= 3'h0;
    else if (serial_select_n)
      bit_pos <= 3'h0;
    else
      bit_pos <= bit_pos + 3'h1;
  end

  // leading bit: only a write word changes the registers
  always_ff @(negedge shift_clock or negedge rst_n)
  begin
    if (!rst_n)
      write_ok <= 1'h0;
    else if (!serial_select_n && phase_of(bit_pos) == dlsc_pkg::PH_WRITE)
      write_ok <= (serial_data_in == dlsc_pkg::WRITE_FLAG);
  end

  // register select, first bit is the high one
  always_ff @(negedge shift_clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_sel <= dlsc_pkg::SEL_TEST;
    else if (!serial_select_n && phase_of(bit_pos) == dlsc_pkg::PH_SELECT)
      reg_sel <= {reg_sel[0], serial_data_in};
  end

  // payload shifts straight into the selected register, msb first
  always_ff @(negedge shift_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < dlsc_pkg::NUM_REGS; i++)
        cfg[i] <= dlsc_pkg::REG_RESET;
    end
    else if (!serial_select_n && link_phase_payload && write_ok)
      cfg[reg_sel] <= {cfg[reg_sel][3:0], serial_data_in};
  end

  // every payload bit of a write word is announced to the clk domain
  always_ff @(negedge shift_clock or negedge rst_n)
  begin
    if (!rst_n)
      word_toggle <= 1'h0;
    else if (!serial_select_n && link_phase_payload && write_ok)
      word_toggle <= ~word_toggle;
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossing into the clk domain
  logic tog_q2;
  logic tog_q3;
  logic tog_seen;
  logic bit_event;

  dlsc_sync #(
    .WIDTH(1)
  ) u_tog_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(word_toggle),
    .q2(tog_q2),
    .q3(tog_q3)
  );

  // the register word stays still for a whole shift half period, far longer than the sync delay
  assign bit_event = (tog_q2 == tog_q3) && (tog_q3 != tog_seen);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tog_seen <= 1'h0;
    else if (ce && bit_event)
      tog_seen <= tog_q3;
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      red_delay_code <= dlsc_pkg::REG_RESET;
      green_delay_code <= dlsc_pkg::REG_RESET;
      blue_delay_code <= dlsc_pkg::REG_RESET;
      red_delay_ns <= '0;
      green_delay_ns <= '0;
      blue_delay_ns <= '0;
    end
    else if (ce && bit_event)
    begin
      red_delay_code <= cfg[dlsc_pkg::SEL_RED];
      green_delay_code <= cfg[dlsc_pkg::SEL_GREEN];
      blue_delay_code <= cfg[dlsc_pkg::SEL_BLUE];
      red_delay_ns <= 6'({1'h0, cfg[dlsc_pkg::SEL_RED]} * dlsc_pkg::DELAY_STEP_NS);
      green_delay_ns <= 6'({1'h0, cfg[dlsc_pkg::SEL_GREEN]} * dlsc_pkg::DELAY_STEP_NS);
      blue_delay_ns <= 6'({1'h0, cfg[dlsc_pkg::SEL_BLUE]} * dlsc_pkg::DELAY_STEP_NS);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // test register outputs
  logic [4:0] test_word;
  logic [3:0] test_slice;

  assign test_word = cfg[dlsc_pkg::SEL_TEST];
  assign test_slice = test_word[dlsc_pkg::SLICE_LSB +: dlsc_pkg::SLICE_W];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_mode <= 1'h0;
      green_shows_slicer <= 1'h0;
      red_blue_probe_self <= 1'h0;
      slice_code <= 4'h0;
      slice_mv <= '0;
    end
    else if (ce && bit_event)
    begin
      test_mode <= test_word[dlsc_pkg::TEST_MODE_BIT];
      green_shows_slicer <= test_word[dlsc_pkg::TEST_MODE_BIT];
      red_blue_probe_self <= test_word[dlsc_pkg::TEST_MODE_BIT];
      slice_code <= test_slice;
      slice_mv <= 10'($signed({{6{test_slice[3]}}, test_slice}) * dlsc_pkg::SLICE_STEP_MV);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      config_update <= 1'h0;
    else if (ce)
      config_update <= bit_event;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks in the link domain
  sequence s_select_bits;
    (bit_pos == dlsc_pkg::SEL_HI_POS) ##1 (bit_pos == dlsc_pkg::SEL_LO_POS);
  endsequence

  property p_first_bit;
    @(negedge shift_clock) disable iff (!rst_n || serial_select_n)
    (bit_pos == dlsc_pkg::WRITE_BIT_POS) |=> (bit_pos == 3'h1) && (write_ok == !$past(serial_data_in));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("leading bit not taken as write flag");

  property p_select;
    @(negedge shift_clock) disable iff (!rst_n || serial_select_n)
    s_select_bits |=> (reg_sel == {$past(serial_data_in, 2), $past(serial_data_in)});
  endproperty
  a_select: assert property (p_select) else $error("register select not built from bits one and two");

  property p_payload_shift;
    @(negedge shift_clock) disable iff (!rst_n || serial_select_n)
    (link_phase_payload && write_ok) |=> (cur_reg == {$past(cur_reg[3:0]), $past(serial_data_in)});
  endproperty
  a_payload_shift: assert property (p_payload_shift) else $error("payload bit not shifted into register");

  property p_word_wrap;
    @(negedge shift_clock) disable iff (!rst_n || serial_select_n)
    (bit_pos == dlsc_pkg::LAST_BIT_POS) |=> (bit_pos == dlsc_pkg::WRITE_BIT_POS);
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("word did not restart after eight bits");

  property p_read_ignored;
    @(negedge shift_clock) disable iff (!rst_n || serial_select_n)
    (link_phase_payload && !write_ok) |=> $stable(word_toggle);
  endproperty
  a_read_ignored: assert property (p_read_ignored) else $error("non-write word changed a register");

  //////////////////////////////////////////////////////////////////////////////
  // checks in the clk domain
  property p_reset_zero;
    @(posedge clk)
    $rose(rst_n) |-> (red_delay_code == 5'h00) && (blue_delay_code == 5'h00) && !test_mode && (slice_code == 4'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");

  property p_delay_scale;
    @(posedge clk) disable iff (!rst_n)
    (ce && bit_event) |=> (red_delay_ns == {$past(cfg[dlsc_pkg::SEL_RED]), 1'h0})
      && (green_delay_ns == {$past(cfg[dlsc_pkg::SEL_GREEN]), 1'h0})
      && (blue_delay_ns == {$past(cfg[dlsc_pkg::SEL_BLUE]), 1'h0});
  endproperty
  a_delay_scale: assert property (p_delay_scale) else $error("delay in ns is not twice the code");

  property p_slice_code;
    @(posedge clk) disable iff (!rst_n)
    (ce && bit_event) |=> (slice_code == $past(test_word[4:1])) && (test_mode == $past(test_word[0]));
  endproperty
  a_slice_code: assert property (p_slice_code) else $error("test register fields misplaced");

  property p_slice_mv;
    @(posedge clk) disable iff (!rst_n)
    (slice_code == 4'h8) ##0 $stable(slice_code) |-> (slice_mv == -10'sd400);
  endproperty
  a_slice_mv: assert property (p_slice_mv) else $error("slicer code 1000 is not -400 mV");

  property p_test_route;
    @(posedge clk) disable iff (!rst_n)
    (ce && bit_event) |=> (green_shows_slicer == test_mode) && (red_blue_probe_self == $past(test_word[0]));
  endproperty
  a_test_route: assert property (p_test_route) else $error("test mode routing does not follow the test bit");

  sequence s_update_pulse;
    config_update ##1 !config_update;
  endsequence

  property p_update_pulse;
    @(posedge clk) disable iff (!rst_n)
    (ce && bit_event) ##1 ce |-> s_update_pulse;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("config update did not pulse once per payload bit");

  property p_idle_hold;
    @(posedge clk) disable iff (!rst_n)
    (serial_select_n && $past(serial_select_n)) |-> $stable(word_toggle) && (bit_pos == dlsc_pkg::WRITE_BIT_POS);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("link state moved while select was high");

endmodule

// ==== design/dlsc_pkg.sv ====
// constants and types of the delay-line serial configuration port
package dlsc_pkg;

  // word framing
  localparam int WORD_BITS = 8;
  localparam logic [2:0] WRITE_BIT_POS = 3'h0;
  localparam logic [2:0] SEL_HI_POS = 3'h1;
  localparam logic [2:0] SEL_LO_POS = 3'h2;
  localparam logic [2:0] FIRST_PAYLOAD_POS = 3'h3;
  localparam logic [2:0] LAST_BIT_POS = 3'h7;
  localparam logic WRITE_FLAG = 1'h0;

  // register select codes
  localparam logic [1:0] SEL_TEST = 2'h0;
  localparam logic [1:0] SEL_RED = 2'h1;
  localparam logic [1:0] SEL_GREEN = 2'h2;
  localparam logic [1:0] SEL_BLUE = 2'h3;
  localparam int NUM_REGS = 4;

  // field layout
  localparam int CODE_W = 5;
  localparam int SLICE_W = 4;
  localparam int TEST_MODE_BIT = 0;
  localparam int SLICE_LSB = 1;
  localparam logic [4:0] REG_RESET = 5'h00;

  // scaling of codes to physical values
  localparam int DELAY_NS_W = 6;
  localparam logic [5:0] DELAY_STEP_NS = 6'h02;
  localparam int SLICE_MV_W = 10;
  localparam logic signed [9:0] SLICE_STEP_MV = 10'sh032;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SHIFT_CLOCK_MAX_MHZ = 10;
  localparam int SHIFT_HALF_PERIOD_NS = 1000 / (2 * SHIFT_CLOCK_MAX_MHZ);
  // whole clk cycles in the shortest shift-clock half period (rounded down)
  localparam int SHIFT_HALF_CYCLES = SHIFT_HALF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;
  localparam int RST_STAGES = 2;

  typedef enum {PH_WRITE, PH_SELECT, PH_PAYLOAD} dlsc_phase_t;

endpackage

// ==== design/dlsc_sync.sv ====
// three-stage synchroniser that exposes its second and third stages
module dlsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q2,
  output logic [WIDTH-1:0] q3
);

  logic [WIDTH-1:0] stage1;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      q2 <= '0;
      q3 <= '0;
    end
    else if (ce)
    begin
      stage1 <= d;
      q2 <= stage1;
      q3 <= q2;
    end
  end

endmodule

// ==== bench/dlsc_ctrl_model.sv ====
// controller model driving the serial configuration lines
module dlsc_ctrl_model (
  output logic shift_clock,
  output logic serial_select_n,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // 125 ns shift period stays below the 10 MHz ceiling
  localparam real HALF_NS = 62.5;

  initial
  begin
    shift_clock = 1'b1;
    serial_select_n = 1'b1;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // one select burst carrying the low n bits of w, msb first
  task automatic frame(input logic [15:0] w, input int n);
    serial_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_in = w[i];
      #(HALF_NS);
      shift_clock = 1'b0;
      #(HALF_NS);
      shift_clock = 1'b1;
    end
    #(HALF_NS);
    serial_select_n = 1'b1;
    // released data line must not keep its last value
    serial_data_in = ~serial_data_in;
  endtask

  ////////////////////////////////////////////////////////////////
  // clock edges with select high, data changing every bit
  task automatic idle_clocks(input int k);
    for (int i = 0; i < k; i++)
    begin
      serial_data_in = ~serial_data_in;
      #(HALF_NS);
      shift_clock = 1'b0;
      #(HALF_NS);
      shift_clock = 1'b1;
    end
  endtask
endmodule

// ==== bench/tb.sv ====
// self-checking testbench of the serial configuration port
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic shift_clock;
  logic serial_select_n;
  logic serial_data_in;
  logic [4:0] red_delay_code;
  logic [4:0] green_delay_code;
  logic [4:0] blue_delay_code;
  logic [5:0] red_delay_ns;
  logic [5:0] green_delay_ns;
  logic [5:0] blue_delay_ns;
  logic test_mode;
  logic [3:0] slice_code;
  logic signed [9:0] slice_mv;
  logic green_shows_slicer;
  logic red_blue_probe_self;
  logic config_update;
  int mismatches = 0;
  int num_checks = 0;
  int pulses = 0;

  always #4 clk = ~clk;

  dlsc_top dlsc_top_i (.clk(clk), .nrst(nrst), .ce(ce), .shift_clock(shift_clock),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .red_delay_code(red_delay_code), .green_delay_code(green_delay_code),
    .blue_delay_code(blue_delay_code), .red_delay_ns(red_delay_ns),
    .green_delay_ns(green_delay_ns), .blue_delay_ns(blue_delay_ns), .test_mode(test_mode),
    .slice_code(slice_code), .slice_mv(slice_mv), .green_shows_slicer(green_shows_slicer),
    .red_blue_probe_self(red_blue_probe_self), .config_update(config_update));

  dlsc_ctrl_model dlsc_ctrl_model_i (.shift_clock(shift_clock),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in));

  always @(posedge clk)
    if (config_update === 1'b1)
      pulses <= pulses + 1;

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a frame, then time for the outputs to cross into clk
  task automatic send(input logic [15:0] w, input int n);
    dlsc_ctrl_model_i.frame(w, n);
    repeat (12) @(negedge clk);
  endtask

  task automatic chk_delays(input logic [4:0] r, input logic [4:0] g, input logic [4:0] b);
    check({5'h00, red_delay_code}, {5'h00, r});
    check({5'h00, green_delay_code}, {5'h00, g});
    check({5'h00, blue_delay_code}, {5'h00, b});
    check({4'h0, red_delay_ns}, {4'h0, r, 1'b0});
    check({4'h0, green_delay_ns}, {4'h0, g, 1'b0});
    check({4'h0, blue_delay_ns}, {4'h0, b, 1'b0});
  endtask

  task automatic chk_test(input logic t, input logic [3:0] s, input logic [9:0] mv);
    check({9'h000, test_mode}, {9'h000, t});
    check({6'h00, slice_code}, {6'h00, s});
    check(slice_mv, mv);
    check({9'h000, green_shows_slicer}, {9'h000, t});
    check({9'h000, red_blue_probe_self}, {9'h000, t});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_reset;
    chk_delays(5'h00, 5'h00, 5'h00);
    chk_test(1'b0, 4'h0, 10'h000);
    $display("test reset done");
  endtask

  task automatic test_channels;
    pulses = 0;
    send(16'h003F, 8);
    send(16'h004A, 8);
    send(16'h0075, 8);
    chk_delays(5'h1F, 5'h0A, 5'h15);
    check(10'(pulses), 10'h00F);
    $display("test channels done");
  endtask

  task automatic test_test_reg;
    send(16'h0011, 8);
    chk_test(1'b1, 4'h8, 10'h270);
    send(16'h000E, 8);
    chk_test(1'b0, 4'h7, 10'h15E);
    $display("test test_reg done");
  endtask

  task automatic test_refused;
    send(16'h00A0, 8);
    chk_delays(5'h1F, 5'h0A, 5'h15);
    $display("test refused done");
  endtask

  task automatic test_burst;
    send(16'h235F, 16);
    chk_delays(5'h03, 5'h1F, 5'h15);
    $display("test burst done");
  endtask

  task automatic test_short;
    send(16'h000E, 5);
    check({5'h00, blue_delay_code}, 10'h016);
    send(16'h0021, 8);
    chk_delays(5'h01, 5'h1F, 5'h16);
    $display("test short done");
  endtask

  task automatic test_hold;
    dlsc_ctrl_model_i.idle_clocks(10);
    repeat (12) @(negedge clk);
    chk_delays(5'h01, 5'h1F, 5'h16);
    $display("test hold done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    ce = 1'b1;
    repeat (5) @(negedge clk);
    test_reset();
    test_channels();
    test_test_reg();
    test_refused();
    test_burst();
    test_short();
    test_hold();
    test_done();
  end

  // the tests need about 13 us
  initial
  begin
    #100000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
